// *** rtss_pkg.sv ***
// Constants shared by the run-time / sleep supervisor: tick rates, register map,
// control field positions, reset values, event bits and the operating states.
// Assumes a single 50 MHz system clock; all times are counted in ticks derived from it.
package rtss_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int unsigned CLK_HZ            = 50_000_000;
  localparam int unsigned DELAY_TICK_MS     = 100;                           // 0.1 s
  localparam int unsigned DELAY_TICK_CYCLES = CLK_HZ / 1000 * DELAY_TICK_MS;
  localparam logic [5:0]  DS_PER_DMIN_M1    = 6'h3B;  // 60 x 0.1 s = 0.1 min
  localparam logic [9:0]  DMIN_PER_HOUR_M1  = 10'h257; // 600 x 0.1 min = 1 h
  localparam logic [15:0] COUNT_SAT         = 16'hFFFF; // 65535 h or 6553.5 min
  localparam logic [7:0]  FAN_TEMP_C        = 8'h28;   // 40 degC

  // ==========================================================================
  // Register map (byte addresses)
  // ==========================================================================
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_ACC_THR   = 8'h04;
  localparam logic [7:0] ADDR_SLP_FREQ  = 8'h08;
  localparam logic [7:0] ADDR_SLP_DLY   = 8'h0C;
  localparam logic [7:0] ADDR_WAK_FREQ  = 8'h10;
  localparam logic [7:0] ADDR_WAK_DLY   = 8'h14;
  localparam logic [7:0] ADDR_DURATION  = 8'h18;
  localparam logic [7:0] ADDR_PER_THR   = 8'h1C;
  localparam logic [7:0] ADDR_STATUS    = 8'h20;
  localparam logic [7:0] ADDR_ACC_COUNT = 8'h24;
  localparam logic [7:0] ADDR_REMAIN    = 8'h28;
  localparam logic [7:0] ADDR_RUN_TIME  = 8'h2C;
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'h30;
  localparam logic [7:0] ADDR_IRQ_MASK  = 8'h34;

  // Control register fields
  localparam int unsigned CTRL_ACTION_BIT  = 0;
  localparam int unsigned CTRL_FAN_BIT     = 1;
  localparam int unsigned CTRL_TIMED_BIT   = 2;
  localparam int unsigned CTRL_SRC_LSB     = 3;
  localparam int unsigned CTRL_PROTECT_BIT = 5;

  // Reset values of the settings
  localparam logic [15:0] CFG_RESET  = 16'h0000;
  localparam logic [4:0]  IRQ_RESET  = 5'h00;

  // Event bits (status and mask share this layout)
  localparam int unsigned IRQ_ACC_BIT   = 0;
  localparam int unsigned IRQ_TIMED_BIT = 1;
  localparam int unsigned IRQ_PER_BIT   = 2;
  localparam int unsigned IRQ_SLEEP_BIT = 3;
  localparam int unsigned IRQ_WAKE_BIT  = 4;
  localparam int unsigned IRQ_W         = 5;

  // ==========================================================================
  // Operating states
  // ==========================================================================
  typedef enum logic [1:0] {
    RTSS_STOPPED  = 2'b00,
    RTSS_RUNNING  = 2'b01,
    RTSS_SLEEPING = 2'b10
  } rtss_state_t;

endpackage : rtss_pkg

// *** rtss_supervisor.sv ***
// Run-time, cooling-fan, sleep/wake, timed-run and startup-protection supervisor.
// Assumes synchronous inputs, a plain register port and a drive core that runs
// while drive_run_o is high.
//
// Functional notes
// - Flag when accumulated run hours reach threshold.
// - Accumulated threshold is whole hours, 0..65535.
// - On reach, action 0 continues, 1 stops.
// - Fan mode 0: fan on while running.
// - Fan mode 0 stopped: fan follows 40 degC.
// - Fan mode 1: fan always on.
// - Low set frequency for sleep delay: sleep.
// - In sleep, high frequency for wake delay: restart.
// - Both frequencies zero disables sleep and wake.
// - Timed run stops drive and flags at duration.
// - Timed run restarts at zero each startup.
// - Duration from setting or scaled analog input.
// - Duration counted in 0.1 min up to 6553.5.
// - Flag when present run reaches per-run threshold.
// - Run command active at power-on is ignored once protection is enabled.
// - Run command held through fault reset ignored once protection is enabled.
`timescale 1ns/1ps
`default_nettype none

module rtss_supervisor #(
  parameter int unsigned TICK_CYCLES = rtss_pkg::DELAY_TICK_CYCLES,
  parameter int unsigned AI_W        = 12
) (
  input  wire logic            clk_i,
  input  wire logic            rst_n_i,
  input  wire logic [7:0]      reg_addr_i,
  input  wire logic [31:0]     reg_wdata_i,
  input  wire logic            reg_wr_i,
  input  wire logic            reg_rd_i,
  output logic      [31:0]     reg_rdata_o,
  input  wire logic            run_cmd_i,
  input  wire logic            fault_reset_i,
  input  wire logic [15:0]     set_freq_i,
  input  wire logic [7:0]      heatsink_temp_i,
  input  wire logic [AI_W-1:0] analog_input_one_i,
  input  wire logic [AI_W-1:0] analog_input_two_i,
  input  wire logic [AI_W-1:0] analog_input_three_i,
  output logic                 drive_run_o,
  output logic                 sleep_active_o,
  output logic                 fan_on_o,
  output logic                 run_time_reached_o,
  output logic                 timing_reached_o,
  output logic                 per_run_reached_o,
  output logic                 irq_o
);

  localparam int unsigned PRE_W = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYCLES - 1);
  localparam int unsigned      IRQ_W_L  = rtss_pkg::IRQ_W;

  // ==========================================================================
  // State record
  // ==========================================================================
  typedef struct packed {
    rtss_pkg::rtss_state_t state;
    logic [PRE_W-1:0]      pre;
    logic                  ds_tick;
    logic [5:0]            acc_ds;
    logic [9:0]            acc_dmin;
    logic [15:0]           acc_h;
    logic [5:0]            run_ds;
    logic [15:0]           run_dmin;
    logic [15:0]           dly;
    logic                  protect;
    logic                  halt;
    logic                  acc_reached;
    logic                  timed_reached;
    logic                  per_reached;
    logic                  fan;
    logic                  action;
    logic                  fan_mode;
    logic                  timed_en;
    logic [1:0]            src;
    logic                  prot_en;
    logic [15:0]           acc_thr;
    logic [15:0]           slp_f;
    logic [15:0]           slp_d;
    logic [15:0]           wak_f;
    logic [15:0]           wak_d;
    logic [15:0]           dur;
    logic [15:0]           per_thr;
    logic [4:0]            irq_st;
    logic [4:0]            irq_mask;
    logic                  irq;
    logic [31:0]           rdata;
  } rtss_st_t;

  rtss_st_t st_r;
  rtss_st_t st_nxt;

  // ==========================================================================
  // Next-state logic
  // ==========================================================================
  always_comb
  begin
    logic                  cmd_eff;
    logic                  sleep_en;
    logic                  start;
    logic                  acc_stop;
    logic [AI_W-1:0]       ai_sel;
    logic [15+AI_W:0]      prod;
    logic [15:0]           dur_sel;
    logic [15:0]           remain;
    logic [IRQ_W_L-1:0]    ev;
    logic [IRQ_W_L-1:0]    w1c;
    cmd_eff  = 1'b0;
    sleep_en = 1'b0;
    start    = 1'b0;
    acc_stop = 1'b0;
    ai_sel   = '0;
    prod     = '0;
    dur_sel  = '0;
    remain   = '0;
    ev       = '0;
    w1c      = '0;
    st_nxt   = st_r;

    // Base 0.1 s tick; slower ticks are cascaded from it below
    st_nxt.ds_tick = (st_r.pre == PRE_LAST);
    st_nxt.pre     = st_nxt.ds_tick ? '0 : st_r.pre + PRE_W'(1);

    // Protection latch: armed by reset and by a fault reset with the command
    // held; a withdrawn command disarms it. Arming wins over disarming.
    if (!run_cmd_i)
      st_nxt.protect = 1'b0;
    if (fault_reset_i && run_cmd_i)
      st_nxt.protect = 1'b1;
    // The same-cycle fault reset also masks, so no start slips through
    cmd_eff = run_cmd_i && !(st_r.prot_en && (st_r.protect || fault_reset_i));

    // An automatic stop holds until the command is withdrawn once
    if (!run_cmd_i)
      st_nxt.halt = 1'b0;

    // Duration source: setting, or setting scaled by an analog input
    unique case (st_r.src)
      2'b00: ai_sel = '1;
      2'b01: ai_sel = analog_input_one_i;
      2'b10: ai_sel = analog_input_two_i;
      2'b11: ai_sel = analog_input_three_i;
    endcase
    prod    = (16 + AI_W)'(st_r.dur) * (16 + AI_W)'(ai_sel);
    // Full scale is taken as 2^AI_W so the scaling is a plain shift
    dur_sel = (st_r.src == 2'b00) ? st_r.dur : prod[15+AI_W:AI_W];
    remain  = (st_r.run_dmin >= dur_sel) ? 16'h0000 : dur_sel - st_r.run_dmin;

    // Accumulated running time: 0.1 s -> 0.1 min -> hour, saturating
    if (st_r.state == rtss_pkg::RTSS_RUNNING && st_r.ds_tick)
    begin
      if (st_r.acc_ds == rtss_pkg::DS_PER_DMIN_M1)
      begin
        st_nxt.acc_ds = '0;
        if (st_r.acc_dmin == rtss_pkg::DMIN_PER_HOUR_M1)
        begin
          st_nxt.acc_dmin = '0;
          if (st_r.acc_h != rtss_pkg::COUNT_SAT)
            st_nxt.acc_h = st_r.acc_h + 16'h0001;
        end
        else
          st_nxt.acc_dmin = st_r.acc_dmin + 10'h001;
      end
      else
        st_nxt.acc_ds = st_r.acc_ds + 6'h01;
    end
    st_nxt.acc_reached = (st_r.acc_h >= st_r.acc_thr);
    acc_stop = st_r.acc_reached && st_r.action;

    // Present-run time in 0.1 min steps, saturating at 6553.5 min
    if (st_r.state == rtss_pkg::RTSS_RUNNING && st_r.ds_tick)
    begin
      if (st_r.run_ds == rtss_pkg::DS_PER_DMIN_M1)
      begin
        st_nxt.run_ds = '0;
        if (st_r.run_dmin != rtss_pkg::COUNT_SAT)
          st_nxt.run_dmin = st_r.run_dmin + 16'h0001;
      end
      else
        st_nxt.run_ds = st_r.run_ds + 6'h01;
    end
    if (st_r.state == rtss_pkg::RTSS_RUNNING && st_r.run_dmin >= st_r.per_thr)
      st_nxt.per_reached = 1'b1;

    // Sleep and wake are off while both frequencies are zero
    sleep_en = (st_r.slp_f != 16'h0000) || (st_r.wak_f != 16'h0000);

    // Run / sleep sequencing
    unique case (st_r.state)
      rtss_pkg::RTSS_STOPPED:
      begin
        st_nxt.dly = '0;
        if (cmd_eff && !st_r.halt && !acc_stop)
          start = 1'b1;
      end
      rtss_pkg::RTSS_RUNNING:
      begin
        if (!cmd_eff)
          st_nxt.state = rtss_pkg::RTSS_STOPPED;
        else if (acc_stop)
        begin
          st_nxt.state = rtss_pkg::RTSS_STOPPED;
          st_nxt.halt  = 1'b1;
        end
        else if (st_r.timed_en && st_r.run_dmin >= dur_sel)
        begin
          st_nxt.state         = rtss_pkg::RTSS_STOPPED;
          st_nxt.halt          = 1'b1;
          st_nxt.timed_reached = 1'b1;
        end
        else if (sleep_en && set_freq_i <= st_r.slp_f)
        begin
          if (st_r.dly >= st_r.slp_d)
          begin
            st_nxt.state = rtss_pkg::RTSS_SLEEPING;
            ev[rtss_pkg::IRQ_SLEEP_BIT] = 1'b1;
          end
          else if (st_r.ds_tick)
            st_nxt.dly = st_r.dly + 16'h0001;
        end
        else
          st_nxt.dly = '0;
        if (st_nxt.state != rtss_pkg::RTSS_RUNNING)
          st_nxt.dly = '0;
      end
      rtss_pkg::RTSS_SLEEPING:
      begin
        if (!cmd_eff)
        begin
          st_nxt.state = rtss_pkg::RTSS_STOPPED;
          st_nxt.dly   = '0;
        end
        else if (!sleep_en)
          start = 1'b1;
        else if (set_freq_i >= st_r.wak_f)
        begin
          if (st_r.dly >= st_r.wak_d)
          begin
            start = 1'b1;
            ev[rtss_pkg::IRQ_WAKE_BIT] = 1'b1;
          end
          else if (st_r.ds_tick)
            st_nxt.dly = st_r.dly + 16'h0001;
        end
        else
          st_nxt.dly = '0;
      end
      default:
        st_nxt.state = rtss_pkg::RTSS_STOPPED;
    endcase

    // Every startup begins a fresh run and a fresh timed interval
    if (start)
    begin
      st_nxt.state         = rtss_pkg::RTSS_RUNNING;
      st_nxt.dly           = '0;
      st_nxt.run_ds        = '0;
      st_nxt.run_dmin      = '0;
      st_nxt.timed_reached = 1'b0;
      st_nxt.per_reached   = 1'b0;
    end

    // Fan: mode 1 always, else running or hot; hold exactly at 40 degC
    st_nxt.fan = st_r.fan_mode
              || (st_r.state == rtss_pkg::RTSS_RUNNING)
              || ($signed(heatsink_temp_i) > $signed(rtss_pkg::FAN_TEMP_C))
              || (st_r.fan && heatsink_temp_i == rtss_pkg::FAN_TEMP_C);

    // Events on rising flags
    ev[rtss_pkg::IRQ_ACC_BIT]   = st_nxt.acc_reached && !st_r.acc_reached;
    ev[rtss_pkg::IRQ_TIMED_BIT] = st_nxt.timed_reached && !st_r.timed_reached;
    ev[rtss_pkg::IRQ_PER_BIT]   = st_nxt.per_reached && !st_r.per_reached;

    // Register writes
    if (reg_wr_i)
    begin
      unique case (reg_addr_i)
        rtss_pkg::ADDR_CTRL:
        begin
          st_nxt.action   = reg_wdata_i[rtss_pkg::CTRL_ACTION_BIT];
          st_nxt.fan_mode = reg_wdata_i[rtss_pkg::CTRL_FAN_BIT];
          st_nxt.timed_en = reg_wdata_i[rtss_pkg::CTRL_TIMED_BIT];
          st_nxt.src      = reg_wdata_i[rtss_pkg::CTRL_SRC_LSB +: 2];
          st_nxt.prot_en  = reg_wdata_i[rtss_pkg::CTRL_PROTECT_BIT];
        end
        rtss_pkg::ADDR_ACC_THR:  st_nxt.acc_thr  = reg_wdata_i[15:0];
        rtss_pkg::ADDR_SLP_FREQ: st_nxt.slp_f    = reg_wdata_i[15:0];
        rtss_pkg::ADDR_SLP_DLY:  st_nxt.slp_d    = reg_wdata_i[15:0];
        rtss_pkg::ADDR_WAK_FREQ: st_nxt.wak_f    = reg_wdata_i[15:0];
        rtss_pkg::ADDR_WAK_DLY:  st_nxt.wak_d    = reg_wdata_i[15:0];
        rtss_pkg::ADDR_DURATION: st_nxt.dur      = reg_wdata_i[15:0];
        rtss_pkg::ADDR_PER_THR:  st_nxt.per_thr  = reg_wdata_i[15:0];
        rtss_pkg::ADDR_IRQ_STAT: w1c             = reg_wdata_i[IRQ_W_L-1:0];
        rtss_pkg::ADDR_IRQ_MASK: st_nxt.irq_mask = reg_wdata_i[IRQ_W_L-1:0];
        default: ;
      endcase
    end
    // A new event beats a clear of the same bit
    st_nxt.irq_st = (st_r.irq_st & ~w1c) | ev;
    st_nxt.irq    = |(st_nxt.irq_st & st_nxt.irq_mask);

    // Read data lives for exactly one cycle after the strobe
    st_nxt.rdata = 32'h0000_0000;
    if (reg_rd_i)
    begin
      unique case (reg_addr_i)
        rtss_pkg::ADDR_CTRL:
          st_nxt.rdata = {26'h0000000, st_r.prot_en, st_r.src, st_r.timed_en,
                          st_r.fan_mode, st_r.action};
        rtss_pkg::ADDR_ACC_THR:  st_nxt.rdata = {16'h0000, st_r.acc_thr};
        rtss_pkg::ADDR_SLP_FREQ: st_nxt.rdata = {16'h0000, st_r.slp_f};
        rtss_pkg::ADDR_SLP_DLY:  st_nxt.rdata = {16'h0000, st_r.slp_d};
        rtss_pkg::ADDR_WAK_FREQ: st_nxt.rdata = {16'h0000, st_r.wak_f};
        rtss_pkg::ADDR_WAK_DLY:  st_nxt.rdata = {16'h0000, st_r.wak_d};
        rtss_pkg::ADDR_DURATION: st_nxt.rdata = {16'h0000, st_r.dur};
        rtss_pkg::ADDR_PER_THR:  st_nxt.rdata = {16'h0000, st_r.per_thr};
        rtss_pkg::ADDR_STATUS:
          st_nxt.rdata = {24'h000000, st_r.protect, st_r.fan, st_r.per_reached,
                          st_r.timed_reached, st_r.acc_reached, st_r.halt,
                          st_r.state};
        rtss_pkg::ADDR_ACC_COUNT: st_nxt.rdata = {16'h0000, st_r.acc_h};
        rtss_pkg::ADDR_REMAIN:    st_nxt.rdata = {16'h0000, remain};
        rtss_pkg::ADDR_RUN_TIME:  st_nxt.rdata = {16'h0000, st_r.run_dmin};
        rtss_pkg::ADDR_IRQ_STAT:  st_nxt.rdata = {27'h0000000, st_r.irq_st};
        rtss_pkg::ADDR_IRQ_MASK:  st_nxt.rdata = {27'h0000000, st_r.irq_mask};
        default:                  st_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  // Protection comes out of reset armed, but prot_en resets to 0, so a held command starts until prot_en is set
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st_r          <= '0;
      st_r.state    <= rtss_pkg::RTSS_STOPPED;
      st_r.protect  <= 1'b1;
      st_r.acc_thr  <= rtss_pkg::CFG_RESET;
      st_r.irq_st   <= rtss_pkg::IRQ_RESET;
      st_r.irq_mask <= rtss_pkg::IRQ_RESET;
    end
    else
      st_r <= st_nxt;
  end

  // Outputs straight from the state record
  assign reg_rdata_o        = st_r.rdata;
  assign drive_run_o        = (st_r.state == rtss_pkg::RTSS_RUNNING);
  assign sleep_active_o     = (st_r.state == rtss_pkg::RTSS_SLEEPING);
  assign fan_on_o           = st_r.fan;
  assign run_time_reached_o = st_r.acc_reached;
  assign timing_reached_o   = st_r.timed_reached;
  assign per_run_reached_o  = st_r.per_reached;
  assign irq_o              = st_r.irq;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  sequence s_fault_held;
    fault_reset_i && run_cmd_i && st_r.prot_en;
  endsequence

  sequence s_cmd_kept;
    run_cmd_i [*2];
  endsequence

  AST_ACC_FLAG: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (st_r.acc_h >= st_r.acc_thr) |=> run_time_reached_o)
    else $error("accumulated flag missing");

  AST_ACC_STOP: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (run_time_reached_o && st_r.action && drive_run_o) |=> !drive_run_o)
    else $error("drive kept running after reach with stop action");

  AST_FAN_RUN: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!st_r.fan_mode && drive_run_o) |=> fan_on_o)
    else $error("fan off while running");

  AST_FAN_COOL: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!st_r.fan_mode && !drive_run_o
     && $signed(heatsink_temp_i) < $signed(rtss_pkg::FAN_TEMP_C)) |=> !fan_on_o)
    else $error("fan on while stopped and cool");

  AST_FAN_ALWAYS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    st_r.fan_mode |=> fan_on_o)
    else $error("fan off in always-on mode");

  AST_SLEEP_ENTRY: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(sleep_active_o) |-> $past(drive_run_o) && $past(set_freq_i <= st_r.slp_f))
    else $error("sleep entered without low set frequency");

  AST_WAKE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ($past(sleep_active_o) && drive_run_o)
      |-> $past(set_freq_i >= st_r.wak_f) || $past(st_r.slp_f == 16'h0000 && st_r.wak_f == 16'h0000))
    else $error("wake without high set frequency");

  AST_SLEEP_OFF: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (st_r.slp_f == 16'h0000 && st_r.wak_f == 16'h0000 && !sleep_active_o) |=> !sleep_active_o)
    else $error("sleep entered while disabled");

  AST_TIMED_STOP: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(timing_reached_o) |-> !drive_run_o && $past(drive_run_o))
    else $error("timed flag without stop");

  AST_TIMED_ZERO: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(drive_run_o) |-> (st_r.run_dmin == 16'h0000) && !timing_reached_o)
    else $error("run timer not restarted at startup");

  AST_PER_RUN: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (drive_run_o && st_r.run_dmin >= st_r.per_thr) |=> per_run_reached_o)
    else $error("per-run flag missing");

  AST_PROTECT_POWER: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (st_r.prot_en && st_r.protect && !drive_run_o && !sleep_active_o) |=> !drive_run_o)
    else $error("start while protection armed");

  AST_PROTECT_FAULT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_fault_held ##1 s_cmd_kept) |-> !drive_run_o)
    else $error("start from command held through fault reset");

endmodule : rtss_supervisor

`default_nettype wire

// *** rtss_drive_model.sv ***
// Drive-core stand-in: reports the heatsink temperature to the supervisor.
// Assumes the bench sets the ambient level; the core warms while it runs.
`timescale 1ns/1ps
`default_nettype none

module rtss_drive_model (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       drive_run_i,
  input  wire logic [7:0] ambient_i,
  output var  logic [7:0] heatsink_temp_o
);
  // ==========================================================================
  // Heatsink sensor
  // ==========================================================================
  // Registered, so the fan logic sees a sensor that lags by a cycle
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      heatsink_temp_o <= 8'h00;
    else
      heatsink_temp_o <= ambient_i + (drive_run_i ? 8'h0A : 8'h00); // Losses add heat
  end
endmodule : rtss_drive_model

`default_nettype wire

// *** test_run_time_sleep_supervisor.sv ***
// Self-checking bench for the supervisor: register port tasks plus run inputs.
// Assumes the drive model supplies temperature and TICK_CYCLES is set to 4.
`timescale 1ns/1ps
`default_nettype none

module test_run_time_sleep_supervisor;
  // ==========================================================================
  // Signals
  // ==========================================================================
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        run_cmd = 1'b0;
  logic        flt = 1'b0;
  logic [15:0] freq = 16'h0000;
  logic [7:0]  amb = 8'h14;
  logic [11:0] ai1 = 12'h000;
  logic [11:0] ai2 = 12'h000;
  logic [11:0] ai3 = 12'h000;
  logic [31:0] rdata;
  logic [7:0]  temp;
  logic        drv, slp, fan, acc_f, tim_f, per_f, irq;
  int          err_total = 0;
  int          n_checks = 0;
  int          cyc = 0;

  // ==========================================================================
  // Instances and clock
  // ==========================================================================
  rtss_supervisor #(.TICK_CYCLES(4), .AI_W(12)) DUT (.clk_i(clk), .rst_n_i(rst_n),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .run_cmd_i(run_cmd), .fault_reset_i(flt), .set_freq_i(freq),
    .heatsink_temp_i(temp), .analog_input_one_i(ai1), .analog_input_two_i(ai2),
    .analog_input_three_i(ai3), .drive_run_o(drv), .sleep_active_o(slp), .fan_on_o(fan),
    .run_time_reached_o(acc_f), .timing_reached_o(tim_f), .per_run_reached_o(per_f),
    .irq_o(irq));
  rtss_drive_model u_drv (.clk_i(clk), .rst_n_i(rst_n), .drive_run_i(drv),
    .ambient_i(amb), .heatsink_temp_o(temp));
  always #10 clk = ~clk;

  // Cut a hang short; the whole run needs about 2200 cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 12000)
    begin
      err_total++;
      end_sim();
    end
  end

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Lands 1 ns past the edge so registered outputs have settled
  task automatic wait_c(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_c

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg

  // Read data stand only in the cycle after the strobe edge
  task automatic rreg(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("reg_rdata_o", rdata, e);
  endtask : rreg

  // Withdraw then reassert, which a halted or protected start needs
  task automatic start();
    @(posedge clk);
    run_cmd <= 1'b0;
    wait_c(2);
    @(posedge clk);
    run_cmd <= 1'b1;
    wait_c(3);
  endtask : start

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rreg(rtss_pkg::ADDR_CTRL, 32'h0);
    rreg(rtss_pkg::ADDR_ACC_COUNT, 32'h0);
    rreg(8'h3C, 32'h0);
    wreg(rtss_pkg::ADDR_ACC_THR, 32'hFFFF);
    rreg(rtss_pkg::ADDR_ACC_THR, 32'hFFFF);
    wreg(rtss_pkg::ADDR_DURATION, 32'hFFFF);
    rreg(rtss_pkg::ADDR_DURATION, 32'hFFFF);
    wait_c(4);
    chk("fan_on_o", 32'(fan), 32'h0);
    @(posedge clk);
    amb <= 8'h32;
    wait_c(4);
    chk("fan_on_o", 32'(fan), 32'h1);
    @(posedge clk);
    amb <= 8'h14;
    wait_c(4);
    chk("fan_on_o", 32'(fan), 32'h0);
    wreg(rtss_pkg::ADDR_CTRL, 32'h2);
    wait_c(3);
    chk("fan_on_o", 32'(fan), 32'h1);
    // Timed run from the set duration; the per-run threshold is set here for the analog runs below
    wreg(rtss_pkg::ADDR_DURATION, 32'h1);
    wreg(rtss_pkg::ADDR_PER_THR, 32'h2);
    wreg(rtss_pkg::ADDR_CTRL, 32'h4);
    start();
    wait_c(200);
    chk("drive_run_o", 32'(drv), 32'h1);
    chk("fan_on_o", 32'(fan), 32'h1);
    wait_c(80);
    chk("drive_run_o", 32'(drv), 32'h0);
    chk("timing_reached_o", 32'(tim_f), 32'h1);
    rreg(rtss_pkg::ADDR_REMAIN, 32'h0);
    // Half-scale analog input on each source halves the set duration of 4
    wreg(rtss_pkg::ADDR_DURATION, 32'h4);
    for (int s = 1; s <= 3; s++)
    begin
      @(posedge clk);
      ai1 <= (s == 1) ? 12'h800 : 12'h000;
      ai2 <= (s == 2) ? 12'h800 : 12'h000;
      ai3 <= (s == 3) ? 12'h800 : 12'h000;
      wreg(rtss_pkg::ADDR_CTRL, 32'h4 | (32'(s) << 3));
      start();
      chk("timing_reached_o", 32'(tim_f), 32'h0);
      wait_c(440);
      chk("drive_run_o", 32'(drv), 32'h1);
      chk("per_run_reached_o", 32'(per_f), 32'h0);
      wait_c(100);
      chk("drive_run_o", 32'(drv), 32'h0);
      chk("per_run_reached_o", 32'(per_f), 32'h1);
    end
    // Sleep and wake, first with both frequencies at zero
    wreg(rtss_pkg::ADDR_CTRL, 32'h0);
    start();
    wait_c(60);
    chk("sleep_active_o", 32'(slp), 32'h0);
    wreg(rtss_pkg::ADDR_IRQ_STAT, 32'h1F);
    wreg(rtss_pkg::ADDR_IRQ_MASK, 32'h8);
    wreg(rtss_pkg::ADDR_SLP_DLY, 32'h3);
    wreg(rtss_pkg::ADDR_WAK_DLY, 32'h2);
    @(posedge clk);
    freq <= 16'h0032; // 50, below the sleep frequency of 100 written after the wake frequency
    wreg(rtss_pkg::ADDR_WAK_FREQ, 32'hC8);
    wreg(rtss_pkg::ADDR_SLP_FREQ, 32'h64);
    wait_c(1);
    chk("drive_run_o", 32'(drv), 32'h1);
    wait_c(20);
    chk("sleep_active_o", 32'(slp), 32'h1);
    chk("drive_run_o", 32'(drv), 32'h0);
    chk("irq_o", 32'(irq), 32'h1);
    rreg(rtss_pkg::ADDR_IRQ_STAT, 32'h8);
    wreg(rtss_pkg::ADDR_IRQ_STAT, 32'h8);
    wait_c(2);
    chk("irq_o", 32'(irq), 32'h0);
    @(posedge clk);
    freq <= 16'h012C;
    wait_c(2);
    chk("drive_run_o", 32'(drv), 32'h0);
    wait_c(16);
    chk("drive_run_o", 32'(drv), 32'h1);
    rreg(rtss_pkg::ADDR_IRQ_STAT, 32'h10);
    // A command held across a fault reset must be withdrawn once
    wreg(rtss_pkg::ADDR_CTRL, 32'h20);
    @(posedge clk);
    flt <= 1'b1;
    @(posedge clk);
    flt <= 1'b0;
    wait_c(10);
    chk("drive_run_o", 32'(drv), 32'h0);
    start();
    chk("drive_run_o", 32'(drv), 32'h1);
    // Accumulated threshold of zero is already reached
    wreg(rtss_pkg::ADDR_ACC_THR, 32'h0);
    wait_c(3);
    chk("run_time_reached_o", 32'(acc_f), 32'h1);
    chk("drive_run_o", 32'(drv), 32'h1);
    wreg(rtss_pkg::ADDR_CTRL, 32'h1);
    wait_c(3);
    chk("drive_run_o", 32'(drv), 32'h0);
    // Reset with the command held: once protection is on, it holds the drive off
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    wreg(rtss_pkg::ADDR_CTRL, 32'h20);
    wait_c(3);
    chk("drive_run_o", 32'(drv), 32'h0);
    start();
    chk("drive_run_o", 32'(drv), 32'h1);
    end_sim();
  end
endmodule : test_run_time_sleep_supervisor

`default_nettype wire
